/* File: uabw_pkg.sv */
// Purpose: Shared constants and types for the auto-baud, break and wake serial unit
// Assumes: Single 40 MHz clock domain
// Notes: Rate divisor is 16 bits; characters are 8 bits
package uabw_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int DATA_W = 8;
  localparam int DIV_W = 16;
  localparam int FIFO_DEPTH = 4;
  localparam logic [15:0] DIV_RESET = 16'h0000;
  localparam logic [15:0] ABD_START = 16'h0001;
  localparam logic [8:0] ABD_PRE_SLOW = 9'h1ff;
  localparam logic [8:0] ABD_PRE_MID = 9'h07f;
  localparam logic [8:0] ABD_PRE_FAST = 9'h01f;
  localparam logic [5:0] BASE_PRE_SLOW = 6'h3f;
  localparam logic [5:0] BASE_PRE_MID = 6'h0f;
  localparam logic [5:0] BASE_PRE_FAST = 6'h03;
  localparam logic [2:0] ABD_EDGES = 3'h5;
  localparam logic [3:0] BREAK_ZEROS = 4'hc;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [3:0] OS_MID = 4'h7;
  localparam logic [3:0] OS_LAST = 4'hf;
  localparam logic [7:0] BREAK_VALUE = 8'h00;
  typedef struct packed {
    logic brk;
    logic [7:0] data;
  } uabw_tx_word_s;
  typedef struct packed {
    logic frame_err;
    logic [7:0] data;
  } uabw_rx_word_s;
endpackage

/* File: uabw_fifo.sv */
// Purpose: Small valid/ready FIFO for transmit words
// Assumes: Same clock as the serial unit
// Notes: Full and empty are exact; no write when full, no read when empty
`timescale 1ns/1ps
`default_nettype none
module uabw_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0] cnt_ff;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem[rp_ff];
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wp_ff] <= in_data;
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wp_ff <= (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
      end
      if (pop) begin
        rp_ff <= (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // uabw_fifo
`default_nettype wire

/* File: uabw_top.sv */
// Purpose: Serial unit extensions: auto-baud, overflow, wake on break, break send and receive
// Assumes: Inputs synchronous to ref_clk except rx_line and sleep wake path
// Notes: Control bits are plain ports; set/clear strobes are one-cycle pulses
// Operation
// - Autobaud enable starts calibration; divisor measures the 55h sync character
// - Receiver stays idle and assembles nothing while measuring
// - Counting starts on first rising edge after the start bit
// - Fifth rising edge stores count, clears enable, sets receive flag
// - Measurement counter ticks at one eighth of the base rate clock
// - Autobaud clock is osc/512, osc/128 or osc/32 per selects
// - Both divisor halves form one 16-bit counter while measuring
// - Counter starts at one; software subtracts one afterwards
// - With wake enabled too, measure the character after the break
// - Overflow sets overflow flag and receive flag, counting continues
// - Idle reads zero while measuring; fifth edge sets receive flag again
// - Wake enable stops reception; receiver watches for a falling edge
// - Wake edge sets receive flag, asynchronously in sleep; read clears it
// - Rising edge ending the break clears wake enable in hardware
// - Nonzero character while waking: first low time is the wake event
// - Sent break is start bit, twelve zero bits, stop bit
// - Buffer write with send break and transmit enable sends a break
// - Send break clears after stop bit; preloaded byte follows normally
// - Received break gives receive flag, framing error and 00h
`timescale 1ns/1ps
`default_nettype none
module uabw_top (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic rx_line,
  input wire logic sleep_mode,
  input wire logic wide_divisor_select,
  input wire logic high_speed_select,
  input wire logic transmit_enable,
  input wire logic receive_enable,
  input wire logic autobaud_enable_set,
  input wire logic autobaud_enable_clr,
  input wire logic wake_on_break_enable_set,
  input wire logic wake_on_break_enable_clr,
  input wire logic send_break_set,
  input wire logic autobaud_overflow_clr,
  input wire logic divisor_wr,
  input wire logic [15:0] divisor_wdata,
  input wire logic transmit_buffer_wr,
  input wire logic [7:0] transmit_buffer_wdata,
  input wire logic receive_buffer_rd,
  output logic transmit_buffer_ready,
  output logic tx_line,
  output logic [15:0] rate_divisor,
  output logic autobaud_enable,
  output logic autobaud_overflow,
  output logic wake_on_break_enable,
  output logic send_break,
  output logic receive_flag,
  output logic receiver_idle,
  output logic framing_error,
  output logic [7:0] receive_buffer,
  output logic shift_register_empty
);
  // ********************************************************
  // Receive line synchroniser and edges
  // ********************************************************
  logic rx_meta_ff, rx_sync_ff, rx_prev_ff;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_meta_ff <= 1'b1;
      rx_sync_ff <= 1'b1;
      rx_prev_ff <= 1'b1;
    end else begin
      rx_meta_ff <= rx_line;
      rx_sync_ff <= rx_meta_ff;
      rx_prev_ff <= rx_sync_ff;
    end
  end
  wire rx_rise = rx_sync_ff && !rx_prev_ff;
  wire rx_fall = !rx_sync_ff && rx_prev_ff;

  // Sleep wake: clock may be stopped, so a latch on the raw line catches the edge
  logic sleep_wake_ff, sleep_wake_ack_ff;
  always_ff @(negedge rx_line or negedge resetn) begin
    if (!resetn) begin
      sleep_wake_ff <= 1'b0;
    end else begin
      sleep_wake_ff <= ~sleep_wake_ack_ff;
    end
  end
  logic sw_meta_ff, sw_sync_ff;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sw_meta_ff <= 1'b0;
      sw_sync_ff <= 1'b0;
      sleep_wake_ack_ff <= 1'b0;
    end else begin
      sw_meta_ff <= sleep_wake_ff;
      sw_sync_ff <= sw_meta_ff;
      sleep_wake_ack_ff <= sw_sync_ff;
    end
  end
  // Toggle-style pulse: new toggle differs from acknowledged copy
  wire sleep_wake_evt = (sw_sync_ff != sleep_wake_ack_ff);

  // ********************************************************
  // Rate prescalers
  // ********************************************************
  function automatic logic [1:0] rate_sel(input logic w, input logic h);
    rate_sel = {w & h, w ^ h};
  endfunction
  wire [1:0] sel = rate_sel(wide_divisor_select, high_speed_select);
  logic [8:0] pre_ff;
  wire [8:0] abd_top = (sel == 2'b10) ? uabw_pkg::ABD_PRE_FAST :
                       (sel == 2'b01) ? uabw_pkg::ABD_PRE_MID : uabw_pkg::ABD_PRE_SLOW;
  wire [8:0] base_top = (sel == 2'b10) ? 9'(uabw_pkg::BASE_PRE_FAST) :
                        (sel == 2'b01) ? 9'(uabw_pkg::BASE_PRE_MID) : 9'(uabw_pkg::BASE_PRE_SLOW);
  logic abd_run_ff;
  // Auto-baud tick is eight base periods, giving average bit time
  wire [8:0] pre_top = abd_run_ff ? abd_top : base_top;
  wire pre_tick = (pre_ff >= pre_top);
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= pre_tick ? '0 : pre_ff + 9'h001;
    end
  end

  // ********************************************************
  // Auto-baud and wake control
  // ********************************************************
  typedef enum logic [1:0] {UABW_AB_OFF = 2'b00, UABW_AB_WAIT_START = 2'b01,
    UABW_AB_WAIT_RISE = 2'b10, UABW_AB_COUNT = 2'b11} uabw_ab_e;
  uabw_ab_e ab_ff, nxt_ab;
  logic [2:0] edges_ff;
  logic [15:0] div_ff;
  logic autobaud_enable_ff, wue_ff, ovf_ff, wake_low_ff;
  wire ab_fifth = (ab_ff == UABW_AB_COUNT) && rx_rise && (edges_ff == uabw_pkg::ABD_EDGES - 3'h1);
  wire ab_wrap = (ab_ff == UABW_AB_COUNT) && pre_tick && (div_ff == 16'hffff);
  always_comb begin
    nxt_ab = ab_ff;
    case (ab_ff)
      UABW_AB_OFF: if (autobaud_enable_ff && !wue_ff) nxt_ab = UABW_AB_WAIT_START;
      UABW_AB_WAIT_START: if (rx_fall) nxt_ab = UABW_AB_WAIT_RISE;
      UABW_AB_WAIT_RISE: if (rx_rise) nxt_ab = UABW_AB_COUNT;
      UABW_AB_COUNT: if (ab_fifth) nxt_ab = UABW_AB_OFF;
      default: nxt_ab = UABW_AB_OFF;
    endcase
    if (!autobaud_enable_ff) nxt_ab = UABW_AB_OFF;
  end
  // Asleep the clocked edge path may miss the fall, so the raw latch decides
  wire wake_fall = wue_ff && (sleep_mode ? sleep_wake_evt : rx_fall);
  wire wake_end = wue_ff && wake_low_ff && rx_rise;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ab_ff <= UABW_AB_OFF;
      edges_ff <= '0;
      autobaud_enable_ff <= 1'b0;
      wue_ff <= 1'b0;
      wake_low_ff <= 1'b0;
      ovf_ff <= 1'b0;
      abd_run_ff <= 1'b0;
    end else begin
      ab_ff <= nxt_ab;
      abd_run_ff <= (nxt_ab != UABW_AB_OFF);
      if (ab_ff == UABW_AB_WAIT_RISE) edges_ff <= 3'h1;
      else if (ab_ff == UABW_AB_COUNT && rx_rise) edges_ff <= edges_ff + 3'h1;
      if (ab_fifth) autobaud_enable_ff <= 1'b0;
      else if (autobaud_enable_set) autobaud_enable_ff <= 1'b1;
      else if (autobaud_enable_clr) autobaud_enable_ff <= 1'b0;
      if (ab_wrap) ovf_ff <= 1'b1;
      else if (autobaud_overflow_clr) ovf_ff <= 1'b0;
      if (wake_end) wue_ff <= 1'b0;
      else if (wake_on_break_enable_set) wue_ff <= 1'b1;
      else if (wake_on_break_enable_clr) wue_ff <= 1'b0;
      // Any first low time ends the wake, even a nonzero character
      if (!wue_ff || wake_end) wake_low_ff <= 1'b0;
      else if (wake_fall) wake_low_ff <= 1'b1;
    end
  end

  // ********************************************************
  // Divisor counter
  // ********************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_ff <= uabw_pkg::DIV_RESET;
    end else if (ab_ff == UABW_AB_WAIT_RISE) begin
      div_ff <= uabw_pkg::ABD_START;
    end else if (ab_ff == UABW_AB_COUNT && pre_tick && !ab_fifth) begin
      div_ff <= div_ff + 16'h0001;
    end else if (divisor_wr && ab_ff == UABW_AB_OFF) begin
      div_ff <= divisor_wdata;
    end
  end

  // ********************************************************
  // Receiver
  // ********************************************************
  typedef enum logic [1:0] {UABW_RX_IDLE = 2'b00, UABW_RX_START = 2'b01,
    UABW_RX_DATA = 2'b10, UABW_RX_STOP = 2'b11} uabw_rx_e;
  uabw_rx_e rx_ff, nxt_rx;
  logic [15:0] bit_cnt_ff;
  logic [3:0] os_ff, nbit_ff;
  logic [7:0] shift_ff;
  uabw_pkg::uabw_rx_word_s rxw_ff;
  logic receive_flag_ff;
  wire rx_block = autobaud_enable_ff || wue_ff;
  wire os_tick = (bit_cnt_ff == '0);
  wire os_done = os_tick && (os_ff == uabw_pkg::OS_LAST);
  wire os_mid = os_tick && (os_ff == uabw_pkg::OS_MID);
  always_comb begin
    nxt_rx = rx_ff;
    case (rx_ff)
      UABW_RX_IDLE: if (rx_fall && receive_enable && !rx_block) nxt_rx = UABW_RX_START;
      UABW_RX_START: if (os_mid) nxt_rx = rx_sync_ff ? UABW_RX_IDLE : UABW_RX_DATA;
      UABW_RX_DATA: if (os_mid && nbit_ff == uabw_pkg::DATA_BITS - 4'h1) nxt_rx = UABW_RX_STOP;
      UABW_RX_STOP: if (os_mid) nxt_rx = UABW_RX_IDLE;
      default: nxt_rx = UABW_RX_IDLE;
    endcase
    if (rx_block) nxt_rx = UABW_RX_IDLE;
  end
  wire rx_done = (rx_ff == UABW_RX_STOP) && os_mid;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_ff <= UABW_RX_IDLE;
      bit_cnt_ff <= '0;
      os_ff <= '0;
      nbit_ff <= '0;
      shift_ff <= '0;
      rxw_ff <= '0;
    end else begin
      rx_ff <= nxt_rx;
      // Sixteen samples per bit from divisor; divisor 0 is fastest
      if (rx_ff == UABW_RX_IDLE) begin
        bit_cnt_ff <= div_ff;
        os_ff <= '0;
        nbit_ff <= '0;
      end else begin
        bit_cnt_ff <= os_tick ? div_ff : bit_cnt_ff - 16'h0001;
        if (os_tick) begin
          os_ff <= os_done ? '0 : os_ff + 4'h1;
        end
        if (rx_ff == UABW_RX_DATA && os_mid) begin
          shift_ff <= {rx_sync_ff, shift_ff[7:1]};
          nbit_ff <= nbit_ff + 4'h1;
        end
      end
      if (rx_done) begin
        rxw_ff.data <= shift_ff;
        rxw_ff.frame_err <= !rx_sync_ff;
      end
    end
  end
  // Set beats a read in the same cycle
  wire receive_flag_set = rx_done || ab_fifth || ab_wrap || wake_fall;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      receive_flag_ff <= 1'b0;
    end else if (receive_flag_set) begin
      receive_flag_ff <= 1'b1;
    end else if (receive_buffer_rd) begin
      receive_flag_ff <= 1'b0;
    end
  end

  // ********************************************************
  // Transmitter with break
  // ********************************************************
  uabw_pkg::uabw_tx_word_s fin, fout;
  logic fvalid, fready, tx_pop;
  logic send_break_ff, txd_ff, tx_busy_ff, tx_brk_ff, brk_q_ff;
  logic [9:0] tx_bits_ff;
  logic [3:0] tx_left_ff, tx_os_ff;
  logic [15:0] tx_cnt_ff;
  // One break word per send_break, so a preloaded byte goes out as data
  assign fin.brk = send_break_ff && transmit_enable && !brk_q_ff;
  assign fin.data = fin.brk ? uabw_pkg::BREAK_VALUE : transmit_buffer_wdata;
  uabw_fifo #(.WIDTH(9), .DEPTH(uabw_pkg::FIFO_DEPTH)) uabw_fifo_inst (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .in_data(fin),
    .in_valid(transmit_buffer_wr && transmit_enable),
    .in_ready(fready),
    .out_data(fout),
    .out_valid(fvalid),
    .out_ready(tx_pop)
  );
  assign tx_pop = !tx_busy_ff && transmit_enable;
  wire tx_bit_end = tx_busy_ff && tx_cnt_ff == '0 && tx_os_ff == uabw_pkg::OS_LAST;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      send_break_ff <= 1'b0;
      txd_ff <= 1'b1;
      tx_busy_ff <= 1'b0;
      tx_brk_ff <= 1'b0;
      brk_q_ff <= 1'b0;
      tx_bits_ff <= '1;
      tx_left_ff <= '0;
      tx_os_ff <= '0;
      tx_cnt_ff <= '0;
    end else begin
      if (tx_bit_end && tx_left_ff == 4'h0 && tx_brk_ff) begin
        send_break_ff <= 1'b0;
      end else if (send_break_set) begin
        send_break_ff <= 1'b1;
      end
      brk_q_ff <= send_break_ff && (brk_q_ff || (transmit_buffer_wr && fin.brk && fready));
      if (tx_pop && fvalid) begin
        tx_busy_ff <= 1'b1;
        tx_brk_ff <= fout.brk;
        tx_bits_ff <= {1'b1, fout.data, 1'b0};
        // Break: start, twelve zeros, stop
        tx_left_ff <= fout.brk ? uabw_pkg::BREAK_ZEROS + 4'h1 : uabw_pkg::DATA_BITS + 4'h1;
        tx_cnt_ff <= div_ff;
        tx_os_ff <= '0;
        txd_ff <= 1'b0;
      end else if (tx_busy_ff) begin
        tx_cnt_ff <= (tx_cnt_ff == '0) ? div_ff : tx_cnt_ff - 16'h0001;
        if (tx_cnt_ff == '0) tx_os_ff <= tx_os_ff + 4'h1;
        if (tx_bit_end) begin
          if (tx_left_ff == 4'h0) begin
            tx_busy_ff <= 1'b0;
            txd_ff <= 1'b1;
          end else begin
            tx_left_ff <= tx_left_ff - 4'h1;
            tx_bits_ff <= {1'b1, tx_bits_ff[9:1]};
            txd_ff <= tx_brk_ff ? (tx_left_ff == 4'h1) : tx_bits_ff[1];
          end
        end
      end
    end
  end

  // ********************************************************
  // Output registers
  // ********************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_line <= 1'b1;
      rate_divisor <= uabw_pkg::DIV_RESET;
      autobaud_enable <= 1'b0;
      autobaud_overflow <= 1'b0;
      wake_on_break_enable <= 1'b0;
      send_break <= 1'b0;
      receive_flag <= 1'b0;
      receiver_idle <= 1'b1;
      framing_error <= 1'b0;
      receive_buffer <= '0;
      shift_register_empty <= 1'b1;
      transmit_buffer_ready <= 1'b0;
    end else begin
      tx_line <= txd_ff;
      rate_divisor <= div_ff;
      autobaud_enable <= autobaud_enable_ff;
      autobaud_overflow <= ovf_ff;
      wake_on_break_enable <= wue_ff;
      send_break <= send_break_ff;
      receive_flag <= receive_flag_ff;
      receiver_idle <= (rx_ff == UABW_RX_IDLE) && (ab_ff != UABW_AB_COUNT);
      framing_error <= rxw_ff.frame_err;
      receive_buffer <= rxw_ff.data;
      shift_register_empty <= !tx_busy_ff;
      transmit_buffer_ready <= fready;
    end
  end
endmodule // uabw_top
`default_nettype wire

/* File: uabw_checker.sv */
// Purpose: Port assertions for the serial unit
// Assumes: Rate selects steady while measuring
// Notes: Bound into uabw_top
`timescale 1ns/1ps
`default_nettype none
module uabw_checker (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic rx_line,
  input wire logic wide_divisor_select,
  input wire logic high_speed_select,
  input wire logic autobaud_enable_clr,
  input wire logic wake_on_break_enable_clr,
  input wire logic tx_line,
  input wire logic [15:0] rate_divisor,
  input wire logic autobaud_enable,
  input wire logic wake_on_break_enable,
  input wire logic send_break,
  input wire logic receive_flag,
  input wire logic receiver_idle,
  input wire logic [7:0] receive_buffer
);
  // ****************
  // Helpers
  // ****************
  logic [9:0] gap_ff;
  logic [23:0] low_ff;
  // One less than the prescaler period
  wire [9:0] tick_gap = (wide_divisor_select & high_speed_select) ? 10'h01f :
    (wide_divisor_select | high_speed_select) ? 10'h07f : 10'h1ff;
  wire [23:0] brk_len = ({8'h00, rate_divisor} + 24'h000001) * 24'h0000d0;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      gap_ff <= 10'h000;
      low_ff <= 24'h000000;
    end else begin
      gap_ff <= $changed(rate_divisor) ? 10'h000 : gap_ff + 10'h001;
      low_ff <= tx_line ? 24'h000000 : low_ff + 24'h000001;
    end
  end
  // ****************
  // Assertions
  // ****************
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  property p_abd_done;
    $fell(autobaud_enable) && !$past(autobaud_enable_clr) && !$past(autobaud_enable_clr, 2)
      |-> receive_flag && receiver_idle;
  endproperty
  a_abd_done: assert property (p_abd_done) else $error("autobaud end lacks flag");
  property p_abd_step;
    autobaud_enable && $past(autobaud_enable) && $changed(rate_divisor)
      |-> rate_divisor == $past(rate_divisor) + 16'h0001 || rate_divisor == 16'h0001;
  endproperty
  a_abd_step: assert property (p_abd_step) else $error("divisor step wrong");
  property p_abd_rate;
    autobaud_enable && $past(autobaud_enable) && rate_divisor > 16'h0002
      && rate_divisor == $past(rate_divisor) + 16'h0001 |-> gap_ff == tick_gap;
  endproperty
  a_abd_rate: assert property (p_abd_rate) else $error("divisor tick spacing wrong");
  // Eight low cycles flush any rise still in the synchroniser
  property p_wake_hold;
    (!rx_line)[*8] ##0 (wake_on_break_enable && !wake_on_break_enable_clr
      && !$past(wake_on_break_enable_clr)) |=> wake_on_break_enable;
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("wake cleared while low");
  property p_wake_flag;
    wake_on_break_enable && $fell(rx_line) |-> ##[1:6] receive_flag;
  endproperty
  a_wake_flag: assert property (p_wake_flag) else $error("wake edge sets no flag");
  property p_brk_len;
    $rose(tx_line) && send_break |-> low_ff == brk_len;
  endproperty
  a_brk_len: assert property (p_brk_len) else $error("break low time wrong");
  property p_brk_end;
    $fell(send_break) |-> tx_line;
  endproperty
  a_brk_end: assert property (p_brk_end) else $error("break flag cleared early");
  property p_hold_buf;
    (autobaud_enable && $past(autobaud_enable)) || (wake_on_break_enable && $past(wake_on_break_enable))
      |-> $stable(receive_buffer);
  endproperty
  a_hold_buf: assert property (p_hold_buf) else $error("data assembled while held");
  c_abd: cover property ($fell(autobaud_enable));
  c_wake: cover property ($fell(wake_on_break_enable));
  c_brk: cover property ($fell(send_break));
endmodule // uabw_checker
bind uabw_top uabw_checker uabw_checker_inst (
  .ref_clk(ref_clk), .resetn(resetn), .rx_line(rx_line),
  .wide_divisor_select(wide_divisor_select), .high_speed_select(high_speed_select),
  .autobaud_enable_clr(autobaud_enable_clr), .wake_on_break_enable_clr(wake_on_break_enable_clr),
  .tx_line(tx_line), .rate_divisor(rate_divisor), .autobaud_enable(autobaud_enable),
  .wake_on_break_enable(wake_on_break_enable), .send_break(send_break),
  .receive_flag(receive_flag), .receiver_idle(receiver_idle), .receive_buffer(receive_buffer)
);
`default_nettype wire

/* File: uabw_node.sv */
// Purpose: Remote serial node on rx_line and tx_line
// Assumes: Bit length is 64 cycles unless the bench sets it
// Notes: Decoded words are {stop, data}
`timescale 1ns/1ps
`default_nettype none
module uabw_node (
  input wire logic ref_clk,
  input wire logic tx_line,
  output logic rx_line
);
  // ****************
  // Sender and monitor
  // ****************
  int bit_cyc;
  logic [8:0] got_q[$];
  logic [8:0] word;
  initial begin
    bit_cyc = 64;
    rx_line = 1'b1;
  end
  // Bits go out LSB first; line returns to its idle high level
  task automatic send(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rx_line <= bits[i];
      repeat (bit_cyc) @(posedge ref_clk);
    end
    rx_line <= 1'b1;
  endtask
  always begin
    @(negedge tx_line);
    repeat (bit_cyc / 2) @(posedge ref_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (bit_cyc) @(posedge ref_clk);
      word[i] = tx_line;
    end
    got_q.push_back(word);
    wait (tx_line === 1'b1);
  end
endmodule // uabw_node
`default_nettype wire

/* File: uabw_top_tb.sv */
// Purpose: Self-checking bench for the serial unit
// Assumes: Remote node model on the serial lines
// Notes: Autobaud runs use a 512-cycle bit
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    comparisons++; \
    if ((g) !== (e)) begin \
      mismatches++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end
module uabw_top_tb;
  logic ref_clk, resetn, sleep_mode, wide_divisor_select, high_speed_select;
  logic transmit_enable, receive_enable, autobaud_enable_set, autobaud_enable_clr;
  logic wake_on_break_enable_set, wake_on_break_enable_clr, send_break_set;
  logic autobaud_overflow_clr, divisor_wr, transmit_buffer_wr, receive_buffer_rd;
  logic [15:0] divisor_wdata;
  logic [7:0] transmit_buffer_wdata;
  logic rx_line, transmit_buffer_ready, tx_line, autobaud_enable, autobaud_overflow;
  logic wake_on_break_enable, send_break, receive_flag, receiver_idle, framing_error;
  logic shift_register_empty;
  logic [15:0] rate_divisor;
  logic [7:0] receive_buffer;
  int mismatches = 0, comparisons = 0;
  uabw_top uabw_top_inst (
    .ref_clk(ref_clk), .resetn(resetn), .rx_line(rx_line), .sleep_mode(sleep_mode),
    .wide_divisor_select(wide_divisor_select), .high_speed_select(high_speed_select),
    .transmit_enable(transmit_enable), .receive_enable(receive_enable),
    .autobaud_enable_set(autobaud_enable_set), .autobaud_enable_clr(autobaud_enable_clr),
    .wake_on_break_enable_set(wake_on_break_enable_set), .wake_on_break_enable_clr(wake_on_break_enable_clr),
    .send_break_set(send_break_set), .autobaud_overflow_clr(autobaud_overflow_clr),
    .divisor_wr(divisor_wr), .divisor_wdata(divisor_wdata), .transmit_buffer_wr(transmit_buffer_wr),
    .transmit_buffer_wdata(transmit_buffer_wdata), .receive_buffer_rd(receive_buffer_rd),
    .transmit_buffer_ready(transmit_buffer_ready), .tx_line(tx_line), .rate_divisor(rate_divisor),
    .autobaud_enable(autobaud_enable), .autobaud_overflow(autobaud_overflow),
    .wake_on_break_enable(wake_on_break_enable), .send_break(send_break), .receive_flag(receive_flag),
    .receiver_idle(receiver_idle), .framing_error(framing_error), .receive_buffer(receive_buffer),
    .shift_register_empty(shift_register_empty)
  );
  uabw_node uabw_node_inst (.ref_clk(ref_clk), .tx_line(tx_line), .rx_line(rx_line));
  // ****************
  // Bus helpers
  // ****************
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic pulse(input logic [2:0] m);
    {autobaud_enable_set, wake_on_break_enable_set, send_break_set} <= m;
    tick(1);
    {autobaud_enable_set, wake_on_break_enable_set, send_break_set} <= 3'h0;
    tick(2);
  endtask
  task automatic rd();
    receive_buffer_rd <= 1'b1;
    tick(1);
    receive_buffer_rd <= 1'b0;
    tick(2);
  endtask
  task automatic wr_tx(input logic [7:0] d);
    transmit_buffer_wdata <= d;
    transmit_buffer_wr <= 1'b1;
    tick(1);
    transmit_buffer_wr <= 1'b0;
    tick(2);
  endtask
  task automatic wait_flag(input int lim);
    for (int i = 0; i < lim && receive_flag !== 1'b1; i++)
      tick(1);
  endtask
  task automatic wait_got(input int n);
    for (int i = 0; i < 9000 && uabw_node_inst.got_q.size() < n; i++)
      tick(1);
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_rx();
    uabw_node_inst.send(16'h034a, 10);
    wait_flag(64);
    `CHK({receive_buffer, framing_error}, 9'h14a)
    rd();
    uabw_node_inst.send(16'h2000, 14);
    wait_flag(64);
    `CHK({receive_flag, framing_error, receive_buffer}, 10'h300)
    rd();
  endtask
  task automatic t_wake(input logic s, input logic [15:0] bits, input int n);
    `CHK(receiver_idle, 1'b1)
    sleep_mode <= s;
    pulse(3'b010);
    fork
      uabw_node_inst.send(bits, n);
    join_none
    tick(32);
    `CHK({receive_flag, wake_on_break_enable}, 2'b11)
    wait fork;
    `CHK(wake_on_break_enable, 1'b0)
    rd();
    `CHK(receive_flag, 1'b0)
    sleep_mode <= 1'b0;
  endtask
  task automatic t_tx();
    transmit_enable <= 1'b1;
    pulse(3'b001);
    `CHK(send_break, 1'b1)
    wr_tx(8'hff);
    wr_tx(8'h55);
    wait_got(2);
    `CHK(uabw_node_inst.got_q[0], 9'h000)
    `CHK({send_break, uabw_node_inst.got_q[1]}, 10'h155)
    uabw_node_inst.got_q.delete();
  endtask
  task automatic t_fifo();
    int n;
    n = 0;
    while (transmit_buffer_ready === 1'b1 && n < 8) begin
      wr_tx(8'h10 + n[7:0]);
      n++;
    end
    `CHK(n > 3 && n < 7, 1'b1)
    wr_tx(8'hee);
    wait_got(n);
    transmit_enable <= 1'b0;
    wr_tx(8'h77);
    tick(800);
    `CHK(uabw_node_inst.got_q.size(), n)
    for (int i = 0; i < n; i++)
      `CHK(uabw_node_inst.got_q[i], 9'h110 + i[8:0])
    `CHK({shift_register_empty, transmit_buffer_ready}, 2'b11)
  endtask
  task automatic t_abd(input logic w, input logic h, input logic wk);
    int e;
    e = 1 + 4096 / ((w & h) ? 32 : (w | h) ? 128 : 512);
    uabw_node_inst.bit_cyc = 512;
    wide_divisor_select <= w;
    high_speed_select <= h;
    pulse({1'b1, wk, 1'b0});
    if (wk) begin
      uabw_node_inst.send(16'h2000, 14);
      `CHK({autobaud_enable, wake_on_break_enable}, 2'b10)
      rd();
    end
    fork
      uabw_node_inst.send(16'h02aa, 10);
    join_none
    tick(1024);
    `CHK({receiver_idle, receive_flag}, 2'b00)
    wait_flag(5000);
    `CHK({autobaud_enable, receive_flag, receiver_idle}, 3'b011)
    `CHK(rate_divisor + 2 >= e && rate_divisor <= e + 2, 1'b1)
    wait fork;
    autobaud_overflow_clr <= 1'b1;
    rd();
    autobaud_overflow_clr <= 1'b0;
    `CHK({receive_flag, autobaud_overflow}, 2'b00)
  endtask
  task results();
    if (mismatches == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    #2500000;
    mismatches++;
    results();
  end
  initial begin
    resetn = 1'b0;
    {sleep_mode, wide_divisor_select, high_speed_select, transmit_enable} = 4'h0;
    {autobaud_enable_set, autobaud_enable_clr, wake_on_break_enable_set} = 3'h0;
    {wake_on_break_enable_clr, send_break_set, autobaud_overflow_clr} = 3'h0;
    {divisor_wr, transmit_buffer_wr, receive_buffer_rd, receive_enable} = 4'h9;
    divisor_wdata = 16'h0003;
    transmit_buffer_wdata = 8'h00;
    tick(2);
    `CHK({tx_line, receiver_idle, shift_register_empty, receive_flag, rate_divisor}, 20'he0000)
    tick(2);
    resetn <= 1'b1;
    tick(2);
    divisor_wr <= 1'b0;
    t_rx();
    t_wake(1'b0, 16'h2000, 14);
    t_wake(1'b1, 16'h2000, 14);
    t_wake(1'b0, 16'h03e0, 10);
    t_tx();
    t_fifo();
    t_abd(1'b0, 1'b0, 1'b0);
    t_abd(1'b0, 1'b1, 1'b0);
    t_abd(1'b1, 1'b0, 1'b0);
    t_abd(1'b1, 1'b1, 1'b1);
    results();
  end
endmodule // uabw_top_tb
`default_nettype wire
